// ===== verilog/cls_pkg.sv
// Constants, field layouts and modes for the configurable logic unit.
//
// Overview of operation
// - Unit holds four slices and runs in logic, arithmetic or memory mode.
// - Each table is any four-input function; a slice pairs two for five.
// - Two slices give six inputs, four give seven, two units give eight.
// - Arithmetic mode adds, subtracts, counts up or down and multiplies.
// - Arithmetic mode reports greater-than, less-than and not-equal flags.
// - Each slice owns two storage registers with full control inputs.
// - Register data comes from the slice table output or from routing.
// - Clock enable polarity is selectable; capture only while enabled.
// - Register captures on rising or falling edge of its own clock.
// - Local set/reset is sync reset, sync set, async reset, async set, off.
// - Global set/reset is async reset, async set or off, on its own net.
// - Global set/reset wins when both set/reset inputs are active.
// - Enable, clock and local set/reset are separate inputs per register.
// - Routing picks table inputs and links outputs inside and outside.
package cls_pkg;

  localparam int CLS_SLICES = 4;
  localparam int CLS_REGS = 8;
  localparam int CLS_TABLE_BITS = 16;

  // Register offsets (byte addresses)
  localparam logic [7:0] CLS_OFS_MODE = 8'h00;
  localparam logic [7:0] CLS_OFS_ROUTE = 8'h04;
  localparam logic [7:0] CLS_OFS_TABLE0 = 8'h10;
  localparam logic [7:0] CLS_OFS_REGCFG0 = 8'h30;
  localparam logic [7:0] CLS_OFS_QSTAT = 8'h60;
  localparam logic [7:0] CLS_OFS_ALUSTAT = 8'h64;
  localparam logic [7:0] CLS_OFS_STRIDE = 8'h04;

  // Mode register fields
  localparam int CLS_MODE_LSB = 0;
  localparam int CLS_OP_LSB = 8;

  // Storage register configuration fields
  localparam int CLS_CFG_DROUTE = 0;
  localparam int CLS_CFG_CELOW = 1;
  localparam int CLS_CFG_FALL = 2;
  localparam int CLS_CFG_SR_LSB = 3;
  localparam int CLS_CFG_GSR_LSB = 6;
  localparam int CLS_CFG_W = 8;

  // Alu status fields
  localparam int CLS_ST_GT = 0;
  localparam int CLS_ST_LT = 1;
  localparam int CLS_ST_NE = 2;
  localparam int CLS_ST_CARRY = 3;
  localparam int CLS_ST_CNT_LSB = 8;

  typedef enum logic [2:0] {
    CLS_MODE_LOGIC = 3'h1,
    CLS_MODE_ARITH = 3'h2,
    CLS_MODE_MEM = 3'h4
  } cls_mode_type;

  typedef enum logic [3:0] {
    CLS_OP_ADD = 4'h1,
    CLS_OP_SUB = 4'h2,
    CLS_OP_COUNT = 4'h4,
    CLS_OP_MULT = 4'h8
  } cls_op_type;

  typedef enum logic [2:0] {
    CLS_SR_NONE = 3'h0,
    CLS_SR_SYNC_RST = 3'h1,
    CLS_SR_SYNC_SET = 3'h2,
    CLS_SR_ASYNC_RST = 3'h3,
    CLS_SR_ASYNC_SET = 3'h4
  } cls_sr_type;

  typedef enum logic [1:0] {
    CLS_GSR_NONE = 2'h0,
    CLS_GSR_ASYNC_RST = 2'h1,
    CLS_GSR_ASYNC_SET = 2'h2
  } cls_gsr_type;

  // Reset values
  localparam logic [2:0] CLS_MODE_RST = 3'h1;
  localparam logic [3:0] CLS_OP_RST = 4'h1;
  localparam logic [15:0] CLS_TABLE_RST = 16'h0000;
  localparam logic [7:0] CLS_CFG_RST = 8'h00;
  localparam logic [3:0] CLS_ROUTE_RST = 4'h0;

endpackage

// ===== verilog/cls_logic_slice.sv
// One logic slice: two four-input tables and their five-input combiner.
`timescale 1ns/100ps
module cls_logic_slice
  import cls_pkg::*;
(
  input wire logic [15:0] table0_in, // Truth table of first table
  input wire logic [15:0] table1_in, // Truth table of second table
  input wire logic [3:0] sel0_in, // Inputs of first table
  input wire logic [3:0] sel1_in, // Inputs of second table
  input wire logic fifth_in, // Fifth input for the combined function
  output logic f0_out, // First table output
  output logic f1_out, // Second table output
  output logic f5_out // Five-input function output
);

  function automatic logic lut4(input logic [15:0] tbl, input logic [3:0] s);
    lut4 = tbl[s];
  endfunction

  // Any four-input function per table
  assign f0_out = lut4(table0_in, sel0_in);
  assign f1_out = lut4(table1_in, sel1_in);

  // Five inputs: both tables see first inputs, fifth input picks one
  assign f5_out = fifth_in ? lut4(table1_in, sel0_in)
                           : lut4(table0_in, sel0_in);

endmodule

// ===== verilog/cls_storage_reg.sv
// One storage register of a slice with its set/reset and edge options.
`timescale 1ns/100ps
module cls_storage_reg
  import cls_pkg::*;
(
  input wire logic mclk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  input wire logic [7:0] cfg_in, // Register configuration word
  input wire logic d_in, // Data input
  input wire logic ce_in, // Clock enable as seen on routing
  input wire logic clk_in, // Register clock level, sampled
  input wire logic sr_in, // Local set/reset
  input wire logic gsr_in, // Global set/reset network
  output logic q_out // Stored value
);

  logic clk_prev_q;
  logic clk_prev_d;
  logic q_q;
  logic q_d;
  logic edge_seen;
  logic ce_act;
  logic [2:0] sr_mode;
  logic [1:0] gsr_mode;

  assign sr_mode = cfg_in[CLS_CFG_SR_LSB +: 3];
  assign gsr_mode = cfg_in[CLS_CFG_GSR_LSB +: 2];

  // Register clock is a fabric signal, so its edges are found on mclk
  assign edge_seen = cfg_in[CLS_CFG_FALL] ? (clk_prev_q & ~clk_in)
                                          : (~clk_prev_q & clk_in);
  assign ce_act = ce_in ^ cfg_in[CLS_CFG_CELOW];

  always_comb
  begin
    clk_prev_d = clk_in;
    q_d = q_q;
    if (gsr_in && gsr_mode == CLS_GSR_ASYNC_RST)
      q_d = 1'b0;
    else if (gsr_in && gsr_mode == CLS_GSR_ASYNC_SET)
      q_d = 1'b1;
    else if (sr_in && sr_mode == CLS_SR_ASYNC_RST)
      q_d = 1'b0;
    else if (sr_in && sr_mode == CLS_SR_ASYNC_SET)
      q_d = 1'b1;
    else if (edge_seen)
    begin
      if (sr_in && sr_mode == CLS_SR_SYNC_RST)
        q_d = 1'b0;
      else if (sr_in && sr_mode == CLS_SR_SYNC_SET)
        q_d = 1'b1;
      else if (ce_act)
        q_d = d_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      clk_prev_q <= 1'b0;
      q_q <= 1'b0;
    end
    else
    begin
      clk_prev_q <= clk_prev_d;
      q_q <= q_d;
    end
  end

  assign q_out = q_q;

endmodule

// ===== verilog/cls_logic_unit.sv
// Configurable logic unit: four slices, arithmetic, memory and registers.
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module cls_logic_unit
  import cls_pkg::*;
#(
  parameter int ALU_W = 8
)
(
  input wire logic mclk_in, // System clock, 20 MHz
  input wire logic rst_in, // Async reset, active high
  input wire logic [7:0] addr_in, // Register byte address
  input wire logic [31:0] wdata_in, // Register write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [31:0] rdata_out, // Read data, cycle after strobe
  input wire logic [31:0] lut_in, // Table inputs, four per table
  input wire logic [3:0] fifth_in, // Fifth input per slice
  input wire logic [1:0] sixth_in, // Sixth input per slice pair
  input wire logic seventh_in, // Seventh input over four slices
  input wire logic eighth_in, // Eighth input, picks neighbour unit
  input wire logic neighbour_f7_in, // Seven-input result of next unit
  output logic [7:0] f4_out, // Four-input table results
  output logic [3:0] f5_out, // Five-input results
  output logic [1:0] f6_out, // Six-input results
  output logic f7_out, // Seven-input result
  output logic f8_out, // Eight-input result
  input wire logic [ALU_W-1:0] alu_a_in, // Arithmetic operand a
  input wire logic [ALU_W-1:0] alu_b_in, // Arithmetic operand b
  input wire logic carry_in, // Carry chain input
  input wire logic count_en_in, // Counter step enable
  input wire logic count_up_in, // Counter direction, high is up
  output logic [2*ALU_W-1:0] alu_result_out, // Arithmetic result
  output logic carry_out, // Carry chain output
  output logic gt_out, // Operand a above b
  output logic lt_out, // Operand a below b
  output logic ne_out, // Operands differ
  input wire logic mem_we_in, // Memory mode write enable
  input wire logic [3:0] mem_addr_in, // Memory mode write address
  input wire logic [7:0] mem_wdata_in, // Memory mode bit per table
  input wire logic [7:0] reg_d_in, // Register data from routing
  input wire logic [7:0] reg_ce_in, // Register clock enables
  input wire logic [7:0] reg_clk_in, // Register clocks, sampled
  input wire logic [7:0] local_set_reset_in, // Local set/reset inputs
  input wire logic global_set_reset_in, // Global set/reset network
  output logic [7:0] q_out // Register outputs
);

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  logic [2:0] mode_q;
  logic [2:0] mode_d;
  logic [3:0] op_q;
  logic [3:0] op_d;
  logic [3:0] route_q;
  logic [3:0] route_d;
  logic [15:0] table_q [CLS_REGS];
  logic [15:0] table_d [CLS_REGS];
  logic [7:0] cfg_q [CLS_REGS];
  logic [7:0] cfg_d [CLS_REGS];
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
                               input int idx);
    hit = (a == base + 8'(idx) * CLS_OFS_STRIDE);
  endfunction

  always_comb
  begin
    mode_d = mode_q;
    op_d = op_q;
    route_d = route_q;
    for (int i = 0; i < CLS_REGS; i++)
    begin
      table_d[i] = table_q[i];
      cfg_d[i] = cfg_q[i];
      // Fabric writes go first so a same-cycle bus write overrides them
      if (mode_q == CLS_MODE_MEM && mem_we_in)
        table_d[i][mem_addr_in] = mem_wdata_in[i];
    end
    if (wr_in)
    begin
      if (addr_in == CLS_OFS_MODE)
      begin
        mode_d = wdata_in[CLS_MODE_LSB +: 3];
        op_d = wdata_in[CLS_OP_LSB +: 4];
      end
      else if (addr_in == CLS_OFS_ROUTE)
        route_d = wdata_in[3:0];
      else
      begin
        for (int i = 0; i < CLS_REGS; i++)
        begin
          if (hit(addr_in, CLS_OFS_TABLE0, i))
            table_d[i] = wdata_in[15:0];
          else if (hit(addr_in, CLS_OFS_REGCFG0, i))
            cfg_d[i] = wdata_in[CLS_CFG_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mode_q <= CLS_MODE_RST;
      op_q <= CLS_OP_RST;
      route_q <= CLS_ROUTE_RST;
      for (int i = 0; i < CLS_REGS; i++)
      begin
        table_q[i] <= CLS_TABLE_RST;
        cfg_q[i] <= CLS_CFG_RST;
      end
    end
    else
    begin
      mode_q <= mode_d;
      op_q <= op_d;
      route_q <= route_d;
      for (int i = 0; i < CLS_REGS; i++)
      begin
        table_q[i] <= table_d[i];
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Slices and wide-function combiners
  // ----------------------------------------------------------------
  logic [7:0] f4;
  logic [3:0] f5;
  logic [1:0] f6;
  logic f7;
  logic [7:0] q;
  logic [31:0] sel;

  genvar s;
  generate
    for (s = 0; s < CLS_SLICES; s++)
    begin : g_slice
      // Routing may feed a slice back its own register outputs
      assign sel[8*s +: 8] = route_q[s] ?
        {lut_in[8*s+6 +: 2], q[2*s+1], q[2*s],
         lut_in[8*s+2 +: 2], q[2*s+1], q[2*s]} :
        lut_in[8*s +: 8];
      cls_logic_slice u_slice (
        .table0_in (table_q[2*s]),
        .table1_in (table_q[2*s+1]),
        .sel0_in (sel[8*s +: 4]),
        .sel1_in (sel[8*s+4 +: 4]),
        .fifth_in (fifth_in[s]),
        .f0_out (f4[2*s]),
        .f1_out (f4[2*s+1]),
        .f5_out (f5[s])
      );
    end
  endgenerate

  assign f6[0] = sixth_in[0] ? f5[1] : f5[0];
  assign f6[1] = sixth_in[1] ? f5[3] : f5[2];
  assign f7 = seventh_in ? f6[1] : f6[0];

  // ----------------------------------------------------------------
  // Arithmetic with carry chain
  // ----------------------------------------------------------------
  logic [ALU_W:0] chain;
  logic [ALU_W-1:0] sum;
  logic [ALU_W-1:0] b_eff;
  logic [ALU_W-1:0] count_q;
  logic [ALU_W-1:0] count_d;
  logic is_sub;

  assign is_sub = (op_q == CLS_OP_SUB);
  assign b_eff = is_sub ? ~alu_b_in : alu_b_in;
  assign chain[0] = is_sub ? 1'b1 : carry_in;

  genvar k;
  generate
    for (k = 0; k < ALU_W; k++)
    begin : g_carry
      assign sum[k] = alu_a_in[k] ^ b_eff[k] ^ chain[k];
      assign chain[k+1] = (alu_a_in[k] & b_eff[k]) |
                          (chain[k] & (alu_a_in[k] ^ b_eff[k]));
    end
  endgenerate

  always_comb
  begin
    count_d = count_q;
    if (mode_q == CLS_MODE_ARITH && op_q == CLS_OP_COUNT && count_en_in)
      count_d = count_up_in ? count_q + ALU_W'(1)
                            : count_q - ALU_W'(1);
  end

  // ----------------------------------------------------------------
  // Registered data outputs
  // ----------------------------------------------------------------
  logic [7:0] f4_q;
  logic [3:0] f5_q;
  logic [1:0] f6_q;
  logic f7_q;
  logic f8_q;
  logic [2*ALU_W-1:0] res_q;
  logic [2*ALU_W-1:0] res_d;
  logic carry_q;
  logic carry_d;
  logic [2:0] cmp_q;
  logic [2:0] cmp_d;

  always_comb
  begin
    res_d = res_q;
    carry_d = carry_q;
    cmp_d = cmp_q;
    if (mode_q == CLS_MODE_ARITH)
    begin
      cmp_d = {alu_a_in != alu_b_in, alu_a_in < alu_b_in,
               alu_a_in > alu_b_in};
      carry_d = chain[ALU_W];
      if (op_q == CLS_OP_MULT)
        res_d = (2*ALU_W)'(alu_a_in) * (2*ALU_W)'(alu_b_in);
      else if (op_q == CLS_OP_COUNT)
        res_d = {{ALU_W{1'b0}}, count_d};
      else
        res_d = {{ALU_W{1'b0}}, sum};
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      f4_q <= 8'h00;
      f5_q <= 4'h0;
      f6_q <= 2'h0;
      f7_q <= 1'b0;
      f8_q <= 1'b0;
      res_q <= '0;
      carry_q <= 1'b0;
      cmp_q <= 3'h0;
      count_q <= '0;
    end
    else
    begin
      f4_q <= f4;
      f5_q <= f5;
      f6_q <= f6;
      f7_q <= f7;
      // Eighth input spans this unit and its neighbour
      f8_q <= eighth_in ? neighbour_f7_in : f7;
      res_q <= res_d;
      carry_q <= carry_d;
      cmp_q <= cmp_d;
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Storage registers, two per slice
  // ----------------------------------------------------------------
  genvar r;
  generate
    for (r = 0; r < CLS_REGS; r++)
    begin : g_reg
      logic d_sel;
      assign d_sel = cfg_q[r][CLS_CFG_DROUTE] ? reg_d_in[r] : f4[r];
      cls_storage_reg u_reg (
        .mclk_in (mclk_in),
        .rst_in (rst_in),
        .cfg_in (cfg_q[r]),
        .d_in (d_sel),
        .ce_in (reg_ce_in[r]),
        .clk_in (reg_clk_in[r]),
        .sr_in (local_set_reset_in[r]),
        .gsr_in (global_set_reset_in),
        .q_out (q[r])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (rd_in)
    begin
      if (addr_in == CLS_OFS_MODE)
      begin
        rdata_d[CLS_MODE_LSB +: 3] = mode_q;
        rdata_d[CLS_OP_LSB +: 4] = op_q;
      end
      else if (addr_in == CLS_OFS_ROUTE)
        rdata_d[3:0] = route_q;
      else if (addr_in == CLS_OFS_QSTAT)
        rdata_d[7:0] = q;
      else if (addr_in == CLS_OFS_ALUSTAT)
      begin
        rdata_d[CLS_ST_GT] = cmp_q[0];
        rdata_d[CLS_ST_LT] = cmp_q[1];
        rdata_d[CLS_ST_NE] = cmp_q[2];
        rdata_d[CLS_ST_CARRY] = carry_q;
        rdata_d[CLS_ST_CNT_LSB +: ALU_W] = count_q;
      end
      else
      begin
        for (int i = 0; i < CLS_REGS; i++)
        begin
          if (hit(addr_in, CLS_OFS_TABLE0, i))
            rdata_d[15:0] = table_q[i];
          else if (hit(addr_in, CLS_OFS_REGCFG0, i))
            rdata_d[CLS_CFG_W-1:0] = cfg_q[i];
        end
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  assign rdata_out = rdata_q;
  assign f4_out = f4_q;
  assign f5_out = f5_q;
  assign f6_out = f6_q;
  assign f7_out = f7_q;
  assign f8_out = f8_q;
  assign alu_result_out = res_q;
  assign carry_out = carry_q;
  assign gt_out = cmp_q[0];
  assign lt_out = cmp_q[1];
  assign ne_out = cmp_q[2];
  assign q_out = q;

endmodule

// ===== tb/cls_fabric_model.sv
// Routing fabric model that drives one register clock pulse per request.
`timescale 1ns/100ps
module cls_fabric_model
(
  input wire logic mclk_in, // System clock
  input wire logic rst_in, // Async reset
  input wire logic go_in, // Pulse request
  output logic clk_out, // Register clock level
  output logic done_out // Pulse finished
);
  // ----
  // Pulse sequencer
  // ----
  // Clock stands low between pulses, as gated fabric clocks do
  logic [2:0] cnt_q;
  assign clk_out = (cnt_q == 3'h2) || (cnt_q == 3'h3);
  assign done_out = (cnt_q == 3'h5);
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_q <= 3'h0;
    else if (go_in || cnt_q != 3'h0)
      cnt_q <= (cnt_q == 3'h5) ? 3'h0 : cnt_q + 3'h1;
  end
endmodule

// ===== tb/cls_logic_unit_assertions.sv
// Port checker for the configurable logic unit.
`timescale 1ns/100ps
module cls_logic_unit_chk
  import cls_pkg::*;
#(
  parameter int ALU_W = 8
)
(
  input wire logic mclk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic [7:0] addr_in, // Address
  input wire logic rd_in, // Read strobe
  input wire logic [31:0] rdata_out, // Read data
  input wire logic eighth_in, // Unit select
  input wire logic neighbour_f7_in, // Next unit result
  input wire logic f7_out, // Own result
  input wire logic f8_out, // Wide result
  input wire logic [ALU_W-1:0] alu_a_in, // Operand a
  input wire logic [ALU_W-1:0] alu_b_in, // Operand b
  input wire logic gt_out, // Above
  input wire logic lt_out, // Below
  input wire logic ne_out, // Differ
  input wire logic [7:0] reg_clk_in, // Register clocks
  input wire logic [7:0] local_set_reset_in, // Local set/reset
  input wire logic global_set_reset_in, // Global set/reset
  input wire logic [7:0] q_out // Register outputs
);
  // ----
  // Properties
  // ----
  // Bench keeps register clocks low in reset, so first $past is clean
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  a_rdata_quiet: assert property (
    !$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read slot");
  a_qstat_read: assert property (
    $past(rd_in) && $past(addr_in) == CLS_OFS_QSTAT
      |-> rdata_out == {24'h0, $past(q_out)})
    else $error("register state readback wrong");
  a_gt_exact: assert property (
    $changed(gt_out) |-> gt_out == ($past(alu_a_in) > $past(alu_b_in)))
    else $error("gt flag disagrees with operands");
  a_lt_exact: assert property (
    $changed(lt_out) |-> lt_out == ($past(alu_a_in) < $past(alu_b_in)))
    else $error("lt flag disagrees with operands");
  a_ne_exact: assert property (
    $changed(ne_out) |-> ne_out == ($past(alu_a_in) != $past(alu_b_in)))
    else $error("ne flag disagrees with operands");
  a_cmp_consistent: assert property (
    !(gt_out && lt_out) && ((gt_out || lt_out) == ne_out))
    else $error("compare flags inconsistent");
  a_f8_pick: assert property (
    f8_out == ($past(eighth_in) ? $past(neighbour_f7_in) : f7_out))
    else $error("eight input select wrong");
  a_q_own_clock: assert property (
    !global_set_reset_in |-> ((q_out ^ $past(q_out)) & ~local_set_reset_in
      & ~($past(reg_clk_in) ^ $past(reg_clk_in, 2))) == 8'h00)
    else $error("register moved without its own controls");
  a_q_hold_idle: assert property (
    $past(reg_clk_in) == $past(reg_clk_in, 2) && local_set_reset_in == 8'h00
      && !global_set_reset_in |-> $stable(q_out))
    else $error("register changed while idle");
endmodule

bind cls_logic_unit cls_logic_unit_chk #(.ALU_W(ALU_W)) u_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .eighth_in(eighth_in), .f7_out(f7_out),
  .neighbour_f7_in(neighbour_f7_in), .f8_out(f8_out), .gt_out(gt_out),
  .alu_a_in(alu_a_in), .alu_b_in(alu_b_in), .lt_out(lt_out),
  .ne_out(ne_out), .reg_clk_in(reg_clk_in), .q_out(q_out),
  .local_set_reset_in(local_set_reset_in),
  .global_set_reset_in(global_set_reset_in)
);

// ===== tb/cls_logic_unit_tb.sv
// Self-checking bench for the configurable logic unit.
`timescale 1ns/100ps
module cls_logic_unit_tb
  import cls_pkg::*;
;
  logic mclk_in = 1'h0, rst_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0;
  logic [7:0] addr_in = 8'h00, alu_a_in = 8'h00, alu_b_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, lut_in = 32'h0, rdata_out;
  logic [3:0] fifth_in = 4'h0, mem_addr_in = 4'h0, f5_out;
  logic [1:0] sixth_in = 2'h0, f6_out;
  logic seventh_in = 1'h0, eighth_in = 1'h0, neighbour_f7_in = 1'h0;
  logic carry_in = 1'h1, count_en_in = 1'h0, count_up_in = 1'h1;
  logic mem_we_in = 1'h0, global_set_reset_in = 1'h0, go = 1'h0;
  logic [7:0] mem_wdata_in = 8'h00, reg_d_in = 8'h00, reg_ce_in = 8'h00;
  logic [7:0] local_set_reset_in = 8'h00, reg_clk_in, f4_out, q_out;
  logic f7_out, f8_out, carry_out, gt_out, lt_out, ne_out, fab_clk, done;
  logic [15:0] alu_result_out;
  int error_cnt = 0, samples_checked = 0;

  assign reg_clk_in = {7'h00, fab_clk};
  always #25 mclk_in = ~mclk_in;

  cls_logic_unit dut (
    .mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .lut_in, .fifth_in, .sixth_in, .seventh_in, .eighth_in,
    .neighbour_f7_in, .f4_out, .f5_out, .f6_out, .f7_out, .f8_out,
    .alu_a_in, .alu_b_in, .carry_in, .count_en_in, .count_up_in,
    .alu_result_out, .carry_out, .gt_out, .lt_out, .ne_out, .mem_we_in,
    .mem_addr_in, .mem_wdata_in, .reg_d_in, .reg_ce_in, .reg_clk_in,
    .local_set_reset_in, .global_set_reset_in, .q_out
  );
  cls_fabric_model fab (
    .mclk_in, .rst_in, .go_in(go), .clk_out(fab_clk), .done_out(done)
  );

  // ----
  // Helpers
  // ----
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'h1;
    @(posedge mclk_in);
    wr_in <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'h1;
    @(posedge mclk_in);
    rd_in <= 1'h0;
    #1;
    d = rdata_out;
  endtask
  // Mid check lands just after the rising edge of the register clock
  task automatic pulse(input logic mid, fin);
    int n;
    @(posedge mclk_in);
    go <= 1'h1;
    @(posedge mclk_in);
    go <= 1'h0;
    for (n = 0; fab_clk !== 1'h1 && n < 8; n++)
      tick(1);
    if (n >= 8)
    begin
      error_cnt++;
      $display("Error at %0t: register clock never rose", $time);
      results();
    end
    tick(1);
    chk(q_out[0], mid);
    for (n = 0; done !== 1'h1 && n < 8; n++)
      tick(1);
    if (n >= 8)
    begin
      error_cnt++;
      $display("Error at %0t: pulse never finished", $time);
      results();
    end
    chk(q_out[0], fin);
  endtask
  task automatic regset(input logic [7:0] c, input logic d, ce, sr, g);
    wr(CLS_OFS_REGCFG0, {24'h0, c});
    reg_d_in <= {7'h7f, d};
    reg_ce_in <= {7'h7f, ce};
    local_set_reset_in <= {7'h00, sr};
    global_set_reset_in <= g;
  endtask
  task automatic alu_case(input logic [3:0] op, input logic [7:0] a, b,
    input logic [15:0] lo, input logic [3:0] fl);
    logic [31:0] v;
    @(posedge mclk_in);
    alu_a_in <= a;
    alu_b_in <= b;
    wr(CLS_OFS_MODE, {20'h0, op, 8'h02});
    tick(2);
    chk(alu_result_out, lo);
    chk(gt_out, fl[0]);
    chk({ne_out, lt_out}, fl[2:1]);
    rd(CLS_OFS_ALUSTAT, v);
    chk(v[2:0], fl[2:0]);
    if (op != CLS_OP_MULT)
      chk(carry_out, fl[3]);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic sc_bus;
    logic [31:0] v;
    rd(CLS_OFS_MODE, v);
    chk(v, 32'h0000_0101);
    wr(CLS_OFS_QSTAT, 32'h0000_00ff);
    rd(CLS_OFS_QSTAT, v);
    chk(v, 32'h0);
    rd(8'hfc, v);
    chk(v, 32'h0);
    wr(CLS_OFS_REGCFG0 + 8'h1c, 32'h0000_0025);
    rd(CLS_OFS_REGCFG0 + 8'h1c, v);
    chk(v, 32'h0000_0025);
  endtask
  task automatic sc_lut;
    wr(CLS_OFS_TABLE0, 32'h0000_8000);
    wr(CLS_OFS_TABLE0 + 8'h1c, 32'h0000_0001);
    lut_in <= 32'h0000_000f;
    eighth_in <= 1'h1;
    neighbour_f7_in <= 1'h1;
    tick(2);
    chk(f4_out, 8'h81);
    chk(f8_out, 1'h1);
    chk(f5_out, 4'h1);
    chk(f6_out, 2'h1);
    chk(f7_out, 1'h1);
    @(posedge mclk_in);
    lut_in <= 32'h1000_000e;
    neighbour_f7_in <= 1'h0;
    fifth_in <= 4'h8;
    sixth_in <= 2'h2;
    seventh_in <= 1'h1;
    tick(2);
    chk(f4_out, 8'h00);
    chk(f8_out, 1'h0);
    chk(f5_out, 4'h8);
    chk(f6_out, 2'h2);
    chk(f7_out, 1'h1);
    // Slice 0 feedback swaps the low index bits for its register outputs
    wr(CLS_OFS_ROUTE, 32'h0000_0001);
    lut_in <= 32'h0000_000f;
    tick(2);
    chk(f4_out, 8'h80);
  endtask
  task automatic sc_alu;
    logic [31:0] v;
    alu_case(CLS_OP_ADD, 8'hf0, 8'h20, 16'h0011, 4'hd);
    alu_case(CLS_OP_SUB, 8'h03, 8'h05, 16'h00fe, 4'h6);
    alu_case(CLS_OP_MULT, 8'h13, 8'h11, 16'h0143, 4'h5);
    wr(CLS_OFS_MODE, 32'h0000_0402);
    count_en_in <= 1'h1;
    repeat (3) @(posedge mclk_in);
    count_up_in <= 1'h0;
    @(posedge mclk_in);
    count_en_in <= 1'h0;
    rd(CLS_OFS_ALUSTAT, v);
    chk(v[15:8], 8'h02);
  endtask
  task automatic sc_mem;
    logic [31:0] v;
    wr(CLS_OFS_MODE, 32'h0000_0104);
    mem_addr_in <= 4'h3;
    mem_wdata_in <= 8'h02;
    mem_we_in <= 1'h1;
    @(posedge mclk_in);
    mem_we_in <= 1'h0;
    rd(CLS_OFS_TABLE0 + 8'h04, v);
    chk(v, 32'h0000_0008);
  endtask
  task automatic sc_reg;
    wr(CLS_OFS_MODE, 32'h0000_0101);
    regset(8'h01, 1'h1, 1'h1, 1'h0, 1'h0);
    pulse(1'h1, 1'h1);
    regset(8'h01, 1'h0, 1'h0, 1'h0, 1'h0);
    pulse(1'h1, 1'h1);
    regset(8'h03, 1'h0, 1'h0, 1'h0, 1'h0);
    pulse(1'h0, 1'h0);
    regset(8'h05, 1'h1, 1'h1, 1'h0, 1'h0);
    pulse(1'h0, 1'h1);
    regset(8'h09, 1'h1, 1'h0, 1'h1, 1'h0);
    tick(3);
    chk(q_out[0], 1'h1);
    pulse(1'h0, 1'h0);
    regset(8'h11, 1'h0, 1'h0, 1'h1, 1'h0);
    pulse(1'h1, 1'h1);
    regset(8'h19, 1'h1, 1'h1, 1'h1, 1'h0);
    tick(2);
    chk(q_out[0], 1'h0);
    regset(8'h21, 1'h0, 1'h0, 1'h1, 1'h0);
    tick(2);
    chk(q_out[0], 1'h1);
    regset(8'h61, 1'h1, 1'h1, 1'h1, 1'h1);
    tick(2);
    chk(q_out[0], 1'h0);
    regset(8'h99, 1'h0, 1'h0, 1'h1, 1'h1);
    tick(2);
    chk(q_out[0], 1'h1);
    regset(8'h41, 1'h1, 1'h0, 1'h0, 1'h1);
    tick(2);
    chk(q_out[0], 1'h0);
    chk(q_out[7:1], 7'h00);
  endtask

  initial
  begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'h0;
    sc_bus();
    sc_lut();
    sc_alu();
    sc_mem();
    sc_reg();
    results();
  end
endmodule
